//--- hw/fsw_pkg.sv
package fsw_pkg;

	// ---------------------------------------------------------------
	// Counter geometry
	// ---------------------------------------------------------------
	localparam int          CNT_W        = 16;
	localparam int          REL_W        = 8;
	localparam int          PRE_W        = 14;
	localparam int          DLY_W        = 8;
	localparam logic [15:0] CNT_ALLONES  = 16'hFFFF;
	localparam logic [15:0] CNT_RST      = 16'h0000;
	localparam logic [7:0]  RELOAD_LOW   = 8'h00;

	// ---------------------------------------------------------------
	// Prescaler: terminal counts for the two ratios (16384 and 256)
	// ---------------------------------------------------------------
	localparam logic [13:0] PRE_TC_LONG  = 14'h3FFF;
	localparam logic [13:0] PRE_TC_SHORT = 14'h00FF;
	localparam logic [13:0] PRE_RST      = 14'h0000;

	// Clock cycles between the prewarning pulse and the reset request
	localparam logic [7:0]  PREWARN_DLY  = 8'h40;
	localparam logic [7:0]  DLY_RST      = 8'h00;

	typedef enum logic [1:0] {
		FSW_WATCH,
		FSW_PREWARN,
		FSW_FAILED
	} fsw_state_t;

endpackage

//--- hw/fsw_prescaler.sv
`timescale 1ns/1ps
module fsw_prescaler
	import fsw_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic clkEn,
	input  wire logic run,
	input  wire logic clear,
	input  wire logic selShort,
	output logic      tick
);

	logic [PRE_W-1:0] preCnt_q;
	logic             tick_q;
	wire logic [13:0] termCount = selShort ? PRE_TC_SHORT : PRE_TC_LONG;
	// Short ratio looks only at the low byte so a ratio change never misses wrap
	wire logic        atTerm    = selShort ? (preCnt_q[7:0] == termCount[7:0])
	                                       : (preCnt_q == termCount);

	// ---------------------------------------------------------------
	// Free divider, cleared by service and by reset
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst || (clkEn && clear)) begin
			preCnt_q <= PRE_RST;
			tick_q   <= 1'b0;
		end else if (clkEn) begin
			tick_q <= run && atTerm;
			if (run) begin
				preCnt_q <= preCnt_q + 14'h0001;
			end
		end
	end

	assign tick = tick_q;

endmodule

//--- hw/fsw_watchdog.sv
`timescale 1ns/1ps
// Functional notes
// - After reset the watchdog is enabled and counting with no software action.
// - The disable instruction stops the watchdog and the enable instruction restarts it.
// - An overflow first pulses the prewarning interrupt and only later raises the reset request.
// - The counter is 16 bits and advances on the system clock divided by 16384 or 256.
// - A service before an overflow loads the counter from the reload value and clears the prescaler.
module fsw_watchdog
	import fsw_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	input  wire logic             clkEn,
	input  wire logic             disableInstr,
	input  wire logic             enableInstr,
	input  wire logic             serviceInstr,
	input  wire logic             prescaleShort,
	input  wire logic [REL_W-1:0] reloadValue,
	output logic                  wdtRunning,
	output logic [CNT_W-1:0]      wdtCount,
	output logic                  prewarnIrq,
	output logic                  resetReq
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	fsw_state_t       state_q;
	fsw_state_t       state_d;
	logic             run_q;
	logic             run_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [DLY_W-1:0] dly_q;
	logic [DLY_W-1:0] dly_d;
	logic             irq_q;
	logic             irq_d;
	logic             rstReq_q;
	logic             prescTick;

	// ---------------------------------------------------------------
	// Decode
	// ---------------------------------------------------------------
	// Service only counts while watching; once overflowed the failure path is final
	wire logic watching  = (state_q == FSW_WATCH);
	wire logic doService = watching && serviceInstr;
	wire logic advance   = watching && run_q && prescTick && !serviceInstr;
	wire logic overflow  = advance && (cnt_q == CNT_ALLONES);
	wire logic dlyDone   = (state_q == FSW_PREWARN) && (dly_q == DLY_RST);

	// ---------------------------------------------------------------
	// Prescaler
	// ---------------------------------------------------------------
	// Runs only while watching, so the divider stops with the count after overflow
	fsw_prescaler fsw_prescaler_i (
		.ref_clk  (ref_clk),
		.sys_rst  (sys_rst),
		.clkEn    (clkEn),
		.run      (run_q && watching),
		.clear    (doService),
		.selShort (prescaleShort),
		.tick     (prescTick)
	);

	// ---------------------------------------------------------------
	// Next values
	// ---------------------------------------------------------------
	// Enable wins over disable when both arrive, the fail-safe direction
	assign run_d = enableInstr ? 1'b1 : (disableInstr ? 1'b0 : run_q);

	// Counter next value: load, step, or hold
	assign cnt_d = doService ? {reloadValue, RELOAD_LOW}
	             : advance   ? cnt_q + 16'h0001
	             : cnt_q;

	// Prewarning pulse comes from the overflow cycle alone
	assign irq_d = overflow;

	// ---------------------------------------------------------------
	// Failure sequence
	// ---------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		dly_d   = dly_q;
		case (state_q)
			FSW_WATCH: begin
				if (overflow) begin
					state_d = FSW_PREWARN;
					dly_d   = PREWARN_DLY;
				end
			end
			FSW_PREWARN: begin
				if (dlyDone) begin
					state_d = FSW_FAILED;
				end else begin
					dly_d = dly_q - 8'h01;
				end
			end
			FSW_FAILED: begin
				state_d = FSW_FAILED;
			end
			default: begin
				state_d = FSW_WATCH;
			end
		endcase
	end

	// Application reset arms the watchdog at once
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			state_q <= FSW_WATCH;
			run_q   <= 1'b1;
			cnt_q   <= CNT_RST;
			dly_q   <= DLY_RST;
		end else if (clkEn) begin
			state_q <= state_d;
			run_q   <= run_d;
			cnt_q   <= cnt_d;
			dly_q   <= dly_d;
		end
	end

	// Outputs registered; reset request holds until the system resets us
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			irq_q    <= 1'b0;
			rstReq_q <= 1'b0;
		end else if (clkEn) begin
			irq_q    <= irq_d;
			rstReq_q <= rstReq_q || dlyDone;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// Every output is a register, no logic between flop and port
	assign wdtRunning = run_q;
	assign wdtCount   = cnt_q;
	assign prewarnIrq = irq_q;
	assign resetReq   = rstReq_q;

	// ---------------------------------------------------------------
	// Check helper: enabled cycles spent waiting after the prewarning
	// ---------------------------------------------------------------
	// Kept apart from dly_q so the spacing check does not reuse what it checks
	logic [DLY_W-1:0] sinceIrq_q;

	always_ff @(posedge ref_clk) begin
		if (sys_rst || (clkEn && irq_q)) begin
			sinceIrq_q <= DLY_RST;
		end else if (clkEn && (state_q == FSW_PREWARN)) begin
			sinceIrq_q <= sinceIrq_q + 8'h01;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// Arming, the two instructions and the clock enable
	a_reset_arms: assert property ($fell(sys_rst) |-> run_q && cnt_q == CNT_RST)
		else $error("watchdog not armed after reset");
	a_disable_stops: assert property (clkEn && disableInstr && !enableInstr |=> !run_q)
		else $error("disable instruction did not stop watchdog");
	a_enable_starts: assert property (clkEn && enableInstr |=> run_q)
		else $error("enable instruction did not start watchdog");
	a_stopped_holds: assert property (clkEn && !run_q && !serviceInstr |=> $stable(cnt_q))
		else $error("counter moved while stopped");
	a_freeze_all: assert property (!clkEn
		|=> $stable(cnt_q) && $stable(run_q) && $stable(state_q) && $stable(rstReq_q))
		else $error("state moved while clock enable low");

	// Failure sequence: one pulse, a counted wait, then a request that stays
	a_prewarn_first: assert property ($rose(rstReq_q)
		|-> !irq_q ##0 $past(state_q) == FSW_PREWARN)
		else $error("reset request without prewarning phase");
	a_irq_then_wait: assert property (irq_q && clkEn |-> !rstReq_q ##1 !rstReq_q)
		else $error("reset request too close to prewarning");
	a_prewarn_pulse: assert property (clkEn && irq_q |=> !irq_q)
		else $error("prewarning longer than one cycle");
	a_irq_cause: assert property ($rose(irq_q) |-> $past(overflow))
		else $error("prewarning without overflow");
	a_delay_done: assert property (clkEn && dlyDone |=> rstReq_q && state_q == FSW_FAILED)
		else $error("wait ended without reset request");
	a_request_span: assert property ($rose(rstReq_q) |-> sinceIrq_q == PREWARN_DLY)
		else $error("reset request not spaced from prewarning");
	a_request_sticky: assert property (rstReq_q |=> rstReq_q)
		else $error("reset request dropped before reset");
	a_fail_final: assert property (state_q == FSW_FAILED |=> state_q == FSW_FAILED)
		else $error("failure state left without reset");
	a_late_service: assert property (clkEn && serviceInstr && !watching |=> $stable(cnt_q))
		else $error("service accepted after overflow");

	// Counting, loading and the wrap
	a_count_step: assert property (clkEn && advance && cnt_q != CNT_ALLONES
		|=> cnt_q == $past(cnt_q) + 16'h0001)
		else $error("counter did not advance by one");
	a_idle_hold: assert property (clkEn && watching && !prescTick && !serviceInstr
		|=> $stable(cnt_q))
		else $error("counter moved without a prescaler tick");
	a_service_load: assert property (clkEn && doService
		|=> cnt_q == {$past(reloadValue), RELOAD_LOW} && !prescTick)
		else $error("service did not reload counter");
	a_service_clear: assert property (clkEn && doService |=> !prescTick ##1 !prescTick)
		else $error("service did not clear prescaler");
	a_wrap_prewarn: assert property (clkEn && overflow |=> irq_q && state_q == FSW_PREWARN)
		else $error("overflow did not raise prewarning");
	a_wrap_zero: assert property (clkEn && overflow |=> cnt_q == 16'h0000)
		else $error("counter did not wrap to zero");

	// Main scenarios
	c_service: cover property (clkEn && doService);
	c_prewarn: cover property (irq_q);
	c_reset_req: cover property ($rose(rstReq_q));
	c_stopped: cover property (!run_q ##1 run_q);
	c_frozen: cover property (!clkEn ##1 clkEn);

endmodule

//--- verification/fail_safe_watchdog_timer_tb_top.sv
`timescale 1ns/1ps
module fail_safe_watchdog_timer_tb_top
	import fsw_pkg::*;
;
	logic             ref_clk = 0;
	logic             sys_rst = 1;
	logic             disableInstr = 0, enableInstr = 0, serviceInstr = 0;
	logic             clkEn = 1, prescaleShort = 1;
	logic             wdtRunning, prewarnIrq, resetReq;
	logic [REL_W-1:0] reloadValue = 8'h00;
	logic [CNT_W-1:0] wdtCount, held;
	int               errCount = 0, checks = 0, k;

	// ---------------------------------------------------------------
	// Clock, design and watchdog
	// ---------------------------------------------------------------
	// Overflow runs on the short ratio: the long one would take over 4 million cycles
	always #20 ref_clk = ~ref_clk;
	fsw_watchdog fsw_watchdog_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(clkEn),
		.disableInstr(disableInstr), .enableInstr(enableInstr),
		.serviceInstr(serviceInstr), .prescaleShort(prescaleShort), .reloadValue(reloadValue),
		.wdtRunning(wdtRunning), .wdtCount(wdtCount), .prewarnIrq(prewarnIrq),
		.resetReq(resetReq));
	// Span covers one long-ratio step and one short-ratio overflow, with margin
	initial begin
		repeat (95000) @(posedge ref_clk);
		errCount++;
		wrap_up();
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic cmp1(input logic g, input logic e, input string m);
		checks++;
		if (g !== e) begin
			errCount++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic cmp16(input logic [15:0] g, input logic [15:0] e, input string m);
		checks++;
		if (g !== e) begin
			errCount++;
			$display("wrong value at %0t: %s got %h", $time, m, g);
		end
	endtask
	// One-cycle strobes: raised after an edge, dropped after the next, then settle
	task automatic strobe(input logic s, input logic d, input logic e, input logic [7:0] r);
		@(posedge ref_clk);
		serviceInstr <= s;
		disableInstr <= d;
		enableInstr <= e;
		reloadValue <= r;
		@(posedge ref_clk);
		{serviceInstr, disableInstr, enableInstr} <= 3'b000;
		#1;
	endtask
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", checks, errCount);
		if (errCount == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		cmp1(wdtRunning, 1'b1, "not armed");
		cmp16(wdtCount, CNT_RST, "reset count");
		repeat (300) @(posedge ref_clk);
		#1 cmp16(wdtCount, 16'h0001, "no step after reset");
		$display("test reset done");
	endtask
	task automatic t_service();
		strobe(1'b1, 1'b0, 1'b0, 8'hA5);
		cmp16(wdtCount, 16'hA500, "reload");
		repeat (250) @(posedge ref_clk);
		#1 cmp16(wdtCount, 16'hA500, "early step");
		for (k = 0; k < 20 && wdtCount !== 16'hA501; k++) @(posedge ref_clk) #1;
		cmp16(wdtCount, 16'hA501, "late step");
		$display("test service done");
	endtask
	task automatic t_onoff();
		strobe(1'b0, 1'b1, 1'b0, 8'hA5);
		cmp1(wdtRunning, 1'b0, "not stopped");
		held = wdtCount;
		repeat (600) @(posedge ref_clk);
		#1 cmp16(wdtCount, held, "counts while off");
		strobe(1'b0, 1'b1, 1'b1, 8'hA5);
		cmp1(wdtRunning, 1'b1, "not restarted");
		$display("test on off done");
	endtask
	task automatic t_overflow();
		strobe(1'b1, 1'b0, 1'b0, 8'hFF);
		for (k = 0; k < 70000 && prewarnIrq !== 1'b1; k++) @(posedge ref_clk) #1;
		cmp1(prewarnIrq, 1'b1, "no prewarning");
		cmp16(wdtCount, 16'h0000, "count did not wrap at overflow");
		cmp1(resetReq, 1'b0, "reset before prewarning");
		for (k = 0; k < 100 && resetReq !== 1'b1; k++) begin
			@(posedge ref_clk) #1;
			if (k == 0) cmp1(prewarnIrq, 1'b0, "prewarning not a pulse");
		end
		cmp1(k == 65, 1'b1, "reset request delay");
		// Once failed, a late service must not rescue the block
		strobe(1'b1, 1'b0, 1'b0, 8'h12);
		cmp16(wdtCount, 16'h0000, "service after overflow");
		cmp1(resetReq, 1'b1, "reset request dropped");
		$display("test overflow done");
	endtask
	// Clock enable low: neither counting nor instructions may take effect
	task automatic t_freeze();
		@(posedge ref_clk) clkEn <= 1'b0;
		#1 held = wdtCount;
		strobe(1'b1, 1'b1, 1'b0, 8'h77);
		repeat (300) @(posedge ref_clk);
		#1 cmp16(wdtCount, held, "count moved while frozen");
		cmp1(wdtRunning, 1'b1, "disable taken while frozen");
		@(posedge ref_clk) clkEn <= 1'b1;
		$display("test freeze done");
	endtask
	// Long ratio: first step lands 16385 cycles after the service, one full divide of 16384 plus the tick register
	task automatic t_long();
		@(posedge ref_clk) prescaleShort <= 1'b0;
		strobe(1'b1, 1'b0, 1'b0, 8'h30);
		repeat (16384) @(posedge ref_clk);
		#1 cmp16(wdtCount, 16'h3000, "early step long");
		@(posedge ref_clk) #1 cmp16(wdtCount, 16'h3001, "late step long");
		@(posedge ref_clk) prescaleShort <= 1'b1;
		$display("test long done");
	endtask
	// Mid-run reset after failure, with the watchdog disabled: it must come back armed
	task automatic t_rerun();
		strobe(1'b0, 1'b1, 1'b0, 8'h12);
		cmp1(wdtRunning, 1'b0, "not stopped before reset");
		@(posedge ref_clk) sys_rst <= 1'b1;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		#1 cmp1(wdtRunning, 1'b1, "not rearmed");
		cmp16(wdtCount, CNT_RST, "count after reset");
		cmp1(resetReq, 1'b0, "reset request kept");
		strobe(1'b1, 1'b0, 1'b0, 8'h5A);
		cmp16(wdtCount, 16'h5A00, "service refused after reset");
		$display("test rerun done");
	endtask

	// Main sequence: reset held five cycles, then each scenario in turn
	initial begin
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		#1;
		t_reset();
		t_service();
		t_onoff();
		t_freeze();
		t_long();
		t_overflow();
		t_rerun();
		wrap_up();
	end
endmodule
